// ### hdl/gpio_ef_regs.svh
// Purpose: Offsets, field positions, reset values and widths of the
//          two-port GPIO block.
// Assumes: Wishbone byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef GPIO_EF_REGS_SVH
`define GPIO_EF_REGS_SVH

`define GPIO_ADR_W 8
`define PE_W 4
`define PF_W 3

`define OFF_E_LATCH 8'h00
`define OFF_E_DIR 8'h04
`define OFF_E_PULLUP 8'h08
`define OFF_F_LATCH 8'h0C
`define OFF_F_DIR 8'h10
`define OFF_CTRL 8'h14

`define CTRL_SPL_BIT 0
`define CTRL_EXTERNAL_RESET_ENABLE_BIT_BIT 1

`define RST_E_LATCH 4'h0
`define RST_E_DIR 4'h0
`define RST_E_PULLUP 4'h0
`define RST_F_LATCH 3'h0
`define RST_F_DIR 3'h0
`define RST_SPL 1'b0
`define RST_EXTERNAL_RESET_ENABLE_BIT 1'b0

`define PF_OD_PIN 2
`define PF_RST_PIN 2

`endif

// ### hdl/gpio_ef_pkg.sv
// Purpose: Types shared by the two-port GPIO block.
// Assumes: Offsets and reset values live in gpio_ef_regs.svh.
// Notes:   Nothing here is imported; users write gpio_ef_pkg::name.
package gpio_ef_pkg;

   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_E_LATCH = 3'b001,
      SEL_E_DIR = 3'b010,
      SEL_E_PULLUP = 3'b011,
      SEL_F_LATCH = 3'b100,
      SEL_F_DIR = 3'b101,
      SEL_CTRL = 3'b110
   } reg_sel_t;

endpackage

// ### hdl/gpio_pin_cell.sv
// Purpose: One GPIO pin: input synchroniser, standby float, drive,
//          open-drain and pull-up control.
// Assumes: Control inputs come from logic on clk.
// Notes:   All outputs are registered.
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_cell
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic pin_in,
   input wire logic dir,
   input wire logic latch,
   input wire logic pu_en,
   input wire logic float_req,
   input wire logic keep_open,
   input wire logic open_drain,
   input wire logic port_off,
   output logic pin_out,
   output logic pin_oe,
   output logic pin_pu,
   output logic level
);

   logic sync1_ff;
   logic sync2_ff;
   logic out_ff;
   logic oe_ff;
   logic pu_ff;
   logic level_ff;
   logic drive;
   logic nxt_out;
   logic nxt_oe;
   logic nxt_pu;
   logic nxt_level;

   ////////////////////////////////////////////////////////////////////////
   // The standby float overrides the direction bit; an open-drain pin
   // only ever pulls low and releases for a latch value of one.
   assign drive = dir && !float_req && !port_off;
   assign nxt_oe = drive && (!open_drain || !latch);
   assign nxt_out = latch && !open_drain;
   assign nxt_pu = pu_en && !(nxt_oe && !nxt_out);
   assign nxt_level = (float_req && !keep_open) ? 1'b0 : sync2_ff;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end
      else
      begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         out_ff <= 1'b0;
         oe_ff <= 1'b0;
         pu_ff <= 1'b0;
         level_ff <= 1'b0;
      end
      else
      begin
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
         pu_ff <= nxt_pu;
         level_ff <= nxt_level;
      end
   end

   assign pin_out = out_ff;
   assign pin_oe = oe_ff;
   assign pin_pu = pu_ff;
   assign level = level_ff;

endmodule // gpio_pin_cell

`default_nettype wire

// ### hdl/dual_gpio_port_e_f.sv
// Purpose: Four-pin and three-pin GPIO ports behind a Wishbone slave.
// Assumes: Pins are asynchronous; standby, RMW and interrupt enables
//          come from logic on clk.
// Notes:   Registers answer with ack one cycle after the request.
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_ef_regs.svh"

// Behaviour
// - Direction one: pin drives its latch bit; latch writes reach the pin.
// - Direction zero: pin is input; writes update latch without driving.
// - Output pin: data read returns latch value.
// - Input pin: plain read returns pin level; RMW read returns latch.
// - Input pin used by a peripheral still reads pin level likewise.
// - Reset clears all direction bits of both ports.
// - Float bit set in stop or watch: pins high impedance, inputs low.
// - During float, four-pin inputs with interrupt enabled stay open.
// - Float bit clear: standby leaves pins and driven levels unchanged.
// - Four-pin port levels always feed the external interrupt inputs; here float holds those with interrupt disabled low.
// - Pull-up bit one connects the four-pin port pull-up.
// - Pull-up disconnected whenever the pin drives low.
// - Open-drain output pin releases to high impedance for latch one.
// - External reset enabled: three-pin port bit two is not a port.
// - Register bit n controls pin n of each port.
module dual_gpio_port_e_f
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`GPIO_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rmw_read,
   input wire logic standby_entry,
   input wire logic [`PE_W-1:0] ext_irq_enable,
   input wire logic [`PE_W-1:0] four_pin_i,
   output logic [`PE_W-1:0] four_pin_o,
   output logic [`PE_W-1:0] four_pin_oe,
   output logic [`PE_W-1:0] four_pin_pullup,
   output logic [`PE_W-1:0] ext_irq_input,
   input wire logic [`PF_W-1:0] three_pin_i,
   output logic [`PF_W-1:0] three_pin_o,
   output logic [`PF_W-1:0] three_pin_oe
);

   logic ack_ff;
   logic [31:0] dat_ff;
   logic [`PE_W-1:0] latch_e_ff;
   logic [`PE_W-1:0] dir_e_ff;
   logic [`PE_W-1:0] pu_e_ff;
   logic [`PF_W-1:0] latch_f_ff;
   logic [`PF_W-1:0] dir_f_ff;
   logic spl_ff;
   logic external_reset_enable_bit_ff;
   logic nxt_ack;
   logic [31:0] nxt_dat;
   logic take;
   logic wr;
   logic float_now;
   gpio_ef_pkg::reg_sel_t sel;
   logic [`PF_W-1:0] f_level;
   logic [`PF_W-1:0] f_port_off;
   logic [`PE_W-1:0] e_read;
   logic [`PF_W-1:0] f_read;
   logic [7:0] ctrl_rd;
   logic [7:0] rd_byte;

   ////////////////////////////////////////////////////////////////////////
   // Address decode, used by both the write strobes and the read mux.
   function automatic gpio_ef_pkg::reg_sel_t decode
   (
      input logic [`GPIO_ADR_W-1:0] adr
   );
      if (adr == `OFF_E_LATCH)
         decode = gpio_ef_pkg::SEL_E_LATCH;
      else if (adr == `OFF_E_DIR)
         decode = gpio_ef_pkg::SEL_E_DIR;
      else if (adr == `OFF_E_PULLUP)
         decode = gpio_ef_pkg::SEL_E_PULLUP;
      else if (adr == `OFF_F_LATCH)
         decode = gpio_ef_pkg::SEL_F_LATCH;
      else if (adr == `OFF_F_DIR)
         decode = gpio_ef_pkg::SEL_F_DIR;
      else if (adr == `OFF_CTRL)
         decode = gpio_ef_pkg::SEL_CTRL;
      else
         decode = gpio_ef_pkg::SEL_NONE;
   endfunction

   assign sel = decode(wb_adr_i);
   assign take = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr = take && wb_we_i && wb_sel_i[0];
   assign nxt_ack = take;

   ////////////////////////////////////////////////////////////////////////
   // Standby float only acts while the float bit is set.
   assign float_now = spl_ff && standby_entry;

   ////////////////////////////////////////////////////////////////////////
   // Read values: a driven pin or an RMW read shows the latch, an input
   // pin shows its synchronised level, also when a peripheral uses it.
   assign e_read = rmw_read ? latch_e_ff
                 : (dir_e_ff & latch_e_ff)
                 | (~dir_e_ff & ext_irq_input);
   assign f_read = (rmw_read ? latch_f_ff
                 : (dir_f_ff & latch_f_ff) | (~dir_f_ff & f_level))
                 & ~f_port_off;
   assign ctrl_rd = (8'(spl_ff) << `CTRL_SPL_BIT)
                  | (8'(external_reset_enable_bit_ff) << `CTRL_EXTERNAL_RESET_ENABLE_BIT_BIT);
   assign rd_byte =
      (sel == gpio_ef_pkg::SEL_E_LATCH) ? {4'h0, e_read} :
      (sel == gpio_ef_pkg::SEL_E_DIR) ? {4'h0, dir_e_ff} :
      (sel == gpio_ef_pkg::SEL_E_PULLUP) ? {4'h0, pu_e_ff} :
      (sel == gpio_ef_pkg::SEL_F_LATCH) ? {5'h00, f_read} :
      (sel == gpio_ef_pkg::SEL_F_DIR) ? {5'h00, dir_f_ff} :
      (sel == gpio_ef_pkg::SEL_CTRL) ? ctrl_rd : 8'h00;
   assign nxt_dat = (take && !wb_we_i) ? {24'h000000, rd_byte} : 32'h0;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0;
      end
      else
      begin
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;

   ////////////////////////////////////////////////////////////////////////
   // Register file; only the low bits of byte lane 0 are stored.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         latch_e_ff <= `RST_E_LATCH;
         dir_e_ff <= `RST_E_DIR;
         pu_e_ff <= `RST_E_PULLUP;
      end
      else if (wr && sel == gpio_ef_pkg::SEL_E_LATCH)
         latch_e_ff <= wb_dat_i[`PE_W-1:0];
      else if (wr && sel == gpio_ef_pkg::SEL_E_DIR)
         dir_e_ff <= wb_dat_i[`PE_W-1:0];
      else if (wr && sel == gpio_ef_pkg::SEL_E_PULLUP)
         pu_e_ff <= wb_dat_i[`PE_W-1:0];
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         latch_f_ff <= `RST_F_LATCH;
         dir_f_ff <= `RST_F_DIR;
         spl_ff <= `RST_SPL;
         external_reset_enable_bit_ff <= `RST_EXTERNAL_RESET_ENABLE_BIT;
      end
      else if (wr && sel == gpio_ef_pkg::SEL_F_LATCH)
         latch_f_ff <= wb_dat_i[`PF_W-1:0];
      else if (wr && sel == gpio_ef_pkg::SEL_F_DIR)
         dir_f_ff <= wb_dat_i[`PF_W-1:0];
      else if (wr && sel == gpio_ef_pkg::SEL_CTRL)
      begin
         spl_ff <= wb_dat_i[`CTRL_SPL_BIT];
         external_reset_enable_bit_ff <= wb_dat_i[`CTRL_EXTERNAL_RESET_ENABLE_BIT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin cells; bit n of every register steers pin n.
   genvar gi;
   generate
      for (gi = 0; gi < `PE_W; gi = gi + 1)
      begin : g_four
         gpio_pin_cell u_cell
         (
            .clk(clk),
            .nrst(nrst),
            .pin_in(four_pin_i[gi]),
            .dir(dir_e_ff[gi]),
            .latch(latch_e_ff[gi]),
            .pu_en(pu_e_ff[gi]),
            .float_req(float_now),
            .keep_open(ext_irq_enable[gi]),
            .open_drain(1'b0),
            .port_off(1'b0),
            .pin_out(four_pin_o[gi]),
            .pin_oe(four_pin_oe[gi]),
            .pin_pu(four_pin_pullup[gi]),
            .level(ext_irq_input[gi])
         );
      end
      for (gi = 0; gi < `PF_W; gi = gi + 1)
      begin : g_three
         assign f_port_off[gi] = external_reset_enable_bit_ff && (gi == `PF_RST_PIN);
         gpio_pin_cell u_cell
         (
            .clk(clk),
            .nrst(nrst),
            .pin_in(three_pin_i[gi]),
            .dir(dir_f_ff[gi]),
            .latch(latch_f_ff[gi]),
            .pu_en(1'b0),
            .float_req(float_now),
            .keep_open(1'b0),
            .open_drain(gi == `PF_OD_PIN),
            .port_off(f_port_off[gi]),
            .pin_out(three_pin_o[gi]),
            .pin_oe(three_pin_oe[gi]),
            .pin_pu(),
            .level(f_level[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   logic rst_done_ff;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rst_done_ff <= 1'b0;
      else
         rst_done_ff <= 1'b1;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_dir_after_reset: assert property (
      !rst_done_ff |-> (dir_e_ff == 4'h0 && dir_f_ff == 3'h0 &&
                        four_pin_oe == 4'h0 && three_pin_oe == 3'h0))
      else $error("Direction bits not cleared by reset.");

   a_out_follows_latch: assert property (
      !float_now |=>
         ((four_pin_o ^ $past(latch_e_ff)) & $past(dir_e_ff)) == 4'h0 &&
         four_pin_oe == $past(dir_e_ff))
      else $error("Output pin does not show its latch bit.");

   a_input_no_drive: assert property (
      (dir_f_ff == 3'h0) |=> three_pin_oe == 3'h0)
      else $error("Input pin is being driven.");

   a_read_rmw_latch: assert property (
      (take && !wb_we_i && rmw_read && sel == gpio_ef_pkg::SEL_E_LATCH)
      |=> wb_ack_o && wb_dat_o[3:0] == $past(latch_e_ff))
      else $error("RMW read did not return the latch.");

   a_read_pin_level: assert property (
      (take && !wb_we_i && !rmw_read && sel == gpio_ef_pkg::SEL_E_LATCH)
      |=> wb_dat_o == {28'h0, $past((dir_e_ff & latch_e_ff) |
                                    (~dir_e_ff & ext_irq_input))})
      else $error("Plain read returned the wrong level.");

   a_float_hiz: assert property (
      float_now |=> four_pin_oe == 4'h0 && three_pin_oe == 3'h0)
      else $error("Pin driven during standby float.");

   a_float_block: assert property (
      float_now |=> (ext_irq_input & ~$past(ext_irq_enable)) == 4'h0)
      else $error("Blocked input not forced low during float.");

   a_no_float_keep: assert property (
      (!spl_ff && standby_entry) [*2] |->
         four_pin_oe == $past(dir_e_ff))
      else $error("Standby without float changed the pins.");

   a_pullup_low: assert property (
      (four_pin_pullup & four_pin_oe & ~four_pin_o) == 4'h0)
      else $error("Pull-up left on a pin driving low.");

   a_open_drain: assert property (
      (dir_f_ff[2] && latch_f_ff[2] && !float_now) |=>
         !three_pin_oe[2] && !three_pin_o[2])
      else $error("Open-drain pin driven high.");

   a_reset_pin_off: assert property (
      external_reset_enable_bit_ff |=> !three_pin_oe[2])
      else $error("Reset pin used as port.");

   a_ack_single: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("Ack held longer than one cycle.");

   c_rmw_read: cover property (
      take && !wb_we_i && rmw_read && sel == gpio_ef_pkg::SEL_E_LATCH);
   c_float_irq_open: cover property (float_now && ext_irq_enable != 4'h0);
   c_drive_write: cover property (
      wr && sel == gpio_ef_pkg::SEL_E_LATCH && dir_e_ff != 4'h0);
   c_open_drain_low: cover property (three_pin_oe[2]);

endmodule // dual_gpio_port_e_f

`default_nettype wire

// ### dv/gpio_ef_pins.sv
// Purpose: Package pins seen from outside the two GPIO ports.
// Assumes: One outside driver per pin, never fighting the device.
// Notes:   A pin that nobody drives and no pull-up holds high changes every cycle.
`timescale 1ns/1ps
`default_nettype none

module gpio_ef_pins
(
   input wire logic clk,
   input wire logic [3:0] e_o,
   input wire logic [3:0] e_oe,
   input wire logic [3:0] e_pu,
   input wire logic [3:0] e_en,
   input wire logic [3:0] e_val,
   input wire logic [2:0] f_o,
   input wire logic [2:0] f_oe,
   input wire logic [2:0] f_en,
   input wire logic [2:0] f_val,
   output logic [3:0] e_pin,
   output logic [2:0] f_pin
);
   logic wander_ff = 1'b0;

   always_ff @(posedge clk)
   begin
      wander_ff <= ~wander_ff;
   end

   // The device wins, then the outside driver, then the pull-up.
   assign e_pin = (e_oe & e_o) | (~e_oe & e_en & e_val)
      | (~e_oe & ~e_en & (e_pu | {4{wander_ff}}));
   assign f_pin = (f_oe & f_o) | (~f_oe & f_en & f_val)
      | (~f_oe & ~f_en & {3{wander_ff}});
endmodule // gpio_ef_pins

`default_nettype wire

// ### dv/test_dual_gpio_port_e_f.sv
// Purpose: Self-checking bench for the two-port GPIO block.
// Assumes: Register answers come one cycle after the take edge.
// Notes:   Random register, standby and pin settings, fixed seed.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_ef_regs.svh"

module test_dual_gpio_port_e_f;
   logic clk = 1'b0;
   logic nrst, cyc, stb, we, rmw, stby, ack, standby_pin_float_bit, external_reset_enable_bit;
   logic [7:0] adr;
   logic [3:0] sel, irqen, e_i, e_o, e_oe, e_pu, irq;
   logic [3:0] dir_e, lat_e, pu_e, en_e, val_e;
   logic [3:0] x_oe, x_pu, x_lv, x_kn, x_irq, x_ikn;
   logic [2:0] f_i, f_o, f_oe, dir_f, lat_f, en_f, val_f;
   logic [2:0] y_oe, y_in, y_kn, y_rst;
   logic [31:0] dat_i, dat_o, q, w;
   int n_fail = 0;
   int samples_checked = 0;

   always #5 clk = ~clk;

   dual_gpio_port_e_f u_dual_gpio_port_e_f
   (
      .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .rmw_read(rmw),
      .standby_entry(stby), .ext_irq_enable(irqen), .four_pin_i(e_i),
      .four_pin_o(e_o), .four_pin_oe(e_oe), .four_pin_pullup(e_pu),
      .ext_irq_input(irq), .three_pin_i(f_i), .three_pin_o(f_o),
      .three_pin_oe(f_oe)
   );

   gpio_ef_pins u_gpio_ef_pins
   (
      .clk(clk), .e_o(e_o), .e_oe(e_oe), .e_pu(e_pu), .e_en(en_e),
      .e_val(val_e), .f_o(f_o), .f_oe(f_oe), .f_en(en_f), .f_val(val_f),
      .e_pin(e_i), .f_pin(f_i)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (n_fail == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s, input logic r);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr;
      adr <= a;
      dat_i <= d;
      sel <= s;
      rmw <= r;
      @(posedge clk);
      // Only the watchdog ends a wait for the answer.
      while (ack !== 1'b1)
         @(posedge clk);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      rmw <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input logic [31:0] m);
      samples_checked++;
      if ((got & m) !== (exp & m))
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got & m, exp & m);
      end
   endtask

   task automatic reset_check();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (12) @(posedge clk);
      chk(32'({e_oe, f_oe}), 0, '1);
      nrst <= 1'b1;
      wb(0, `OFF_E_DIR, 0, 4'hF, 0);
      chk(q, 0, '1);
      wb(0, `OFF_F_DIR, 0, 4'hF, 0);
      chk(q, 0, '1);
   endtask

   // Pins whose level nobody sets are left out of the known masks.
   function automatic void predict();
      logic fl;
      fl = standby_pin_float_bit & stby;
      x_oe = fl ? 4'h0 : dir_e;
      x_pu = fl ? 4'h0 : pu_e & ~(dir_e & ~lat_e);
      x_lv = (x_oe & lat_e) | (~x_oe & en_e & val_e)
         | (~x_oe & ~en_e & x_pu);
      x_kn = x_oe | en_e | x_pu;
      x_irq = x_lv & ~({4{fl}} & ~irqen);
      x_ikn = x_kn | ({4{fl}} & ~irqen);
      y_oe = fl ? 3'h0 : {dir_f[2] & ~lat_f[2] & ~external_reset_enable_bit, dir_f[1:0]};
      y_in = fl ? 3'h0 : (y_oe & {1'b0, lat_f[1:0]}) | (~y_oe & en_f & val_f);
      y_kn = fl ? 3'h7 : y_oe | en_f;
      y_rst = {external_reset_enable_bit, 2'h0};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #500000;
      n_fail++;
      complete_run();
   end

   initial
   begin
      {nrst, cyc, stb, we, rmw, stby, adr, sel, dat_i} = '0;
      {irqen, en_e, val_e, en_f, val_f} = '0;
      q = $urandom(32'h31CE8659);
      reset_check();
      wb(1, 8'h18, 32'hFF, 4'hF, 0);
      wb(0, 8'h18, 0, 4'hF, 0);
      chk(q, 0, '1);
      for (int it = 0; it < 80; it++)
      begin
         q = $urandom;
         w = $urandom;
         {external_reset_enable_bit, standby_pin_float_bit, pu_e, dir_f, lat_f, dir_e, lat_e} = q[19:0];
         wb(1, `OFF_E_LATCH, {w[31:4], lat_e}, 4'hF, 0);
         wb(1, `OFF_E_DIR, {w[31:4], dir_e}, 4'hF, 0);
         wb(1, `OFF_E_PULLUP, {w[31:4], pu_e}, 4'hF, 0);
         wb(1, `OFF_E_PULLUP, {w[31:4], ~pu_e}, 4'hE, 0);
         wb(1, `OFF_F_LATCH, {w[31:3], lat_f}, 4'hF, 0);
         wb(1, `OFF_F_DIR, {w[31:3], dir_f}, 4'hF, 0);
         wb(1, `OFF_CTRL, {w[31:2], external_reset_enable_bit, standby_pin_float_bit}, 4'hF, 0);
         @(posedge clk);
         q = $urandom;
         stby <= q[0];
         irqen <= q[4:1] & ~dir_e;
         en_e <= q[8:5] & ~dir_e;
         val_e <= q[12:9];
         en_f <= q[15:13] & ~dir_f;
         val_f <= q[18:16];
         repeat (5) @(posedge clk);
         predict();
         chk(32'(e_oe), 32'(x_oe), '1);
         chk(32'(e_o), 32'(lat_e), 32'(x_oe));
         chk(32'(e_pu), 32'(x_pu), {32{~(standby_pin_float_bit & stby)}});
         chk(32'(irq), 32'(x_irq), 32'(x_ikn));
         chk(32'(f_oe), 32'(y_oe), '1);
         chk(32'(f_o), 32'({1'b0, lat_f[1:0]}), 32'(y_oe));
         wb(0, `OFF_E_LATCH, 0, 4'hF, 0);
         chk(q, 32'((dir_e & lat_e) | (~dir_e & x_irq)),
            {28'hFFFFFFF, dir_e | x_ikn});
         wb(0, `OFF_E_LATCH, 0, 4'hF, 1);
         chk(q, 32'(lat_e), '1);
         wb(0, `OFF_F_LATCH, 0, 4'hF, 0);
         chk(q, 32'(((dir_f & lat_f) | (~dir_f & y_in)) & ~y_rst),
            {29'h1FFFFFFF, dir_f | y_kn | y_rst});
         wb(0, `OFF_F_LATCH, 0, 4'hF, 1);
         chk(q, 32'(lat_f & ~y_rst), '1);
         wb(0, `OFF_E_DIR, 0, 4'hF, 0);
         chk(q, 32'(dir_e), '1);
         wb(0, `OFF_F_DIR, 0, 4'hF, 0);
         chk(q, 32'(dir_f), '1);
         wb(0, `OFF_E_PULLUP, 0, 4'hF, 0);
         chk(q, 32'(pu_e), '1);
         wb(0, `OFF_CTRL, 0, 4'hF, 0);
         chk(q, 32'({external_reset_enable_bit, standby_pin_float_bit}), '1);
      end
      reset_check();
      complete_run();
   end
endmodule // test_dual_gpio_port_e_f

`default_nettype wire
